/* File: hw/fp_assist_unit.sv */
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Faults to 0x5c00, traps to 0x5d00
// [RULE2] Status register reachable as application register 40
// [RULE3] Save minimal state before vectoring
// [RULE4] Fault records bundle pointer and restart slot
// [RULE5] Trap records previous address and slot
// [RULE6] Implementation assists only with status field
// [RULE7] Code field marks assist versus other fault
// [RULE8] Trap writes first rounded result
// [RULE9] Trap sets fpa, overflow, underflow, inexact
// [RULE10] Inexact-only trap result is already final
// [RULE11] Scalar approximations fault at range extremes
// [RULE12] Parallel approximations clear predicate instead
// [RULE13] Fault leaves destination and flags untouched
module fp_assist_unit (
  input  wire                           SYS_CLK_I,
  input  wire                           RESET_I,
  input  wire                           CLK_EN_I,
  input  wire fp_assist_pkg::fp_event_t EVENT_I,
  input  wire [63:0]                    RESULT_I,
  input  wire [63:0]                    FLAGS_UPDATE_I,
  input  wire                           AR_WR_I,
  input  wire [6:0]                     AR_ADDR_I,
  input  wire [63:0]                    AR_WDATA_I,
  output logic [63:0]                   AR_RDATA_O,
  output logic                          VECTOR_VALID_O,
  output logic [15:0]                   VECTOR_O,
  output logic [63:0]                   INTERRUPTION_BUNDLE_POINTER_O,
  output logic [1:0]                    SAVED_RESTART_SLOT_INDEX_O,
  output logic [63:0]                   INTERRUPTION_PREVIOUS_ADDRESS_O,
  output logic [1:0]                    EXCEPTION_SLOT_INDEX_O,
  output logic [7:0]                    INTERRUPTION_STATUS_CODE_O,
  output logic                          DEST_WR_O,
  output logic [63:0]                   DEST_DATA_O,
  output logic                          PRED_CLEAR_O
);

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  fp_assist_pkg::exc_kind_t kind;
  logic                     assist;
  logic                     clear_pred;
  logic [7:0]               code;

  fp_assist_classify u_classify (
    .ev_i         (EVENT_I),
    .kind_o       (kind),
    .assist_o     (assist),
    .clear_pred_o (clear_pred),
    .code_o       (code)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [63:0]               fp_status_q;
  fp_assist_pkg::ip_record_t ev_rec;

  // Exception kind
  wire is_fault  = (kind == fp_assist_pkg::KIND_FAULT);
  wire is_trap   = (kind == fp_assist_pkg::KIND_TRAP);
  wire taken     = is_fault | is_trap;                           // [RULE3]

  // Commit only when the event does not fault
  wire ok_commit = EVENT_I.valid & ~is_fault;                    // [RULE13]

  // Vector selection, fault over trap
  wire [15:0] vector_d = is_fault ? fp_assist_pkg::FAULT_VECTOR
                                  : fp_assist_pkg::TRAP_VECTOR;  // [RULE1]

  // Bundle and slot of the current event
  assign ev_rec = '{bundle_addr: EVENT_I.bundle_addr,
                    slot:        EVENT_I.slot};

  // ----------------------------------------------------------------
  // Capture enables
  // ----------------------------------------------------------------
  // Each held output loads only on its own event, frozen by the enable
  wire vec_en    = CLK_EN_I & taken;
  wire fault_en  = CLK_EN_I & is_fault;                          // [RULE4]
  wire trap_en   = CLK_EN_I & is_trap;                           // [RULE5]

  // Result load only for committed events
  wire commit_en = CLK_EN_I & ok_commit;                         // [RULE13]

  // ----------------------------------------------------------------
  // Status register access terms
  // ----------------------------------------------------------------
  // Software write replaced, hardware flags ORed on top
  wire        ar_hit    = (AR_ADDR_I == fp_assist_pkg::FP_STATUS_AR); // [RULE2]
  wire        sw_write  = AR_WR_I & ar_hit;
  wire [63:0] flags_set = ok_commit ? FLAGS_UPDATE_I : 64'h0;    // [RULE13]
  wire [63:0] status_d  = (sw_write ? AR_WDATA_I : fp_status_q)
                          | flags_set;

  // Read data, zero for any other address
  wire [63:0] rdata_d   = ar_hit ? fp_status_q : 64'h0;

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // Hardware flag update ORed onto a software write in the same cycle
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fp_status_q <= fp_assist_pkg::FP_STATUS_RESET;
    end else if (CLK_EN_I) begin
      fp_status_q <= status_d;                                   // [RULE2] [RULE13]
    end
  end

  // Read port, one cycle behind the address
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      AR_RDATA_O <= 64'h0;
    end else if (CLK_EN_I) begin
      AR_RDATA_O <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Vector and status code
  // ----------------------------------------------------------------
  // One-cycle pulse per taken exception
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      VECTOR_VALID_O <= 1'b0;
    end else if (CLK_EN_I) begin
      VECTOR_VALID_O <= taken;                                   // [RULE3]
    end
  end

  // Vector held until the next exception
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      VECTOR_O <= 16'h0;
    end else if (vec_en) begin
      VECTOR_O <= vector_d;                                      // [RULE1]
    end
  end

  // Status code held until the next exception
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      INTERRUPTION_STATUS_CODE_O <= 8'h0;
    end else if (vec_en) begin
      INTERRUPTION_STATUS_CODE_O <= code;                        // [RULE7] [RULE9]
    end
  end

  // ----------------------------------------------------------------
  // Fault record
  // ----------------------------------------------------------------
  // Bundle pointer of the faulting instruction
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      INTERRUPTION_BUNDLE_POINTER_O <= 64'h0;
    end else if (fault_en) begin
      INTERRUPTION_BUNDLE_POINTER_O <= ev_rec.bundle_addr;       // [RULE4]
    end
  end

  // Restart slot of the faulting instruction
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SAVED_RESTART_SLOT_INDEX_O <= 2'h0;
    end else if (fault_en) begin
      SAVED_RESTART_SLOT_INDEX_O <= ev_rec.slot;                 // [RULE4]
    end
  end

  // ----------------------------------------------------------------
  // Trap record
  // ----------------------------------------------------------------
  // Bundle address of the trapping instruction
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      INTERRUPTION_PREVIOUS_ADDRESS_O <= 64'h0;
    end else if (trap_en) begin
      INTERRUPTION_PREVIOUS_ADDRESS_O <= ev_rec.bundle_addr;     // [RULE5]
    end
  end

  // Slot of the trapping instruction
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      EXCEPTION_SLOT_INDEX_O <= 2'h0;
    end else if (trap_en) begin
      EXCEPTION_SLOT_INDEX_O <= ev_rec.slot;                     // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // Destination writeback
  // ----------------------------------------------------------------
  // Write pulse, suppressed on any fault
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      DEST_WR_O <= 1'b0;
    end else if (CLK_EN_I) begin
      DEST_WR_O <= ok_commit;                                    // [RULE8] [RULE13]
    end
  end

  // Result held between writes
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      DEST_DATA_O <= 64'h0;
    end else if (commit_en) begin
      DEST_DATA_O <= RESULT_I;                                   // [RULE8] [RULE10]
    end
  end

  // Predicate clear pulse for parallel approximations
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRED_CLEAR_O <= 1'b0;
    end else if (CLK_EN_I) begin
      PRED_CLEAR_O <= clear_pred;                                // [RULE12]
    end
  end

endmodule

/* File: hw/fp_assist_pkg.sv */
package fp_assist_pkg;

  // ----------------------------------------------------------------
  // Vectors and register addressing
  // ----------------------------------------------------------------
  localparam logic [15:0] FAULT_VECTOR    = 16'h5c00;
  localparam logic [15:0] TRAP_VECTOR     = 16'h5d00;
  localparam logic [6:0]  FP_STATUS_AR    = 7'h28;
  localparam int          FP_STATUS_WIDTH = 64;
  localparam logic [63:0] FP_STATUS_RESET = 64'h0;

  // ----------------------------------------------------------------
  // Status code field positions
  // ----------------------------------------------------------------
  localparam int CODE_BIT_ASSIST = 0;
  localparam int CODE_BIT_FPA    = 1;
  localparam int CODE_BIT_OVF    = 2;
  localparam int CODE_BIT_UNF    = 3;
  localparam int CODE_BIT_INEX   = 4;
  localparam int CODE_WIDTH      = 8;

  // ----------------------------------------------------------------
  // Shared types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        has_status_field;
    logic        scalar_approx;
    logic        parallel_approx;
    logic        operand_extreme;
    logic        hw_cannot_finish;
    logic        first_round_done;
    logic        frac_incremented;
    logic        overflow;
    logic        underflow;
    logic        inexact;
    logic        other_fault;
    logic [63:0] bundle_addr;
    logic [1:0]  slot;
  } fp_event_t;

  typedef struct packed {
    logic [63:0] bundle_addr;
    logic [1:0]  slot;
  } ip_record_t;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_FAULT,
    KIND_TRAP
  } exc_kind_t;

endpackage

/* File: hw/fp_assist_classify.sv */
`timescale 1ns/100ps
module fp_assist_classify (
  input  wire fp_assist_pkg::fp_event_t ev_i,
  output wire fp_assist_pkg::exc_kind_t kind_o,
  output wire                           assist_o,
  output wire                           clear_pred_o,
  output wire [7:0]                     code_o
);

  // --------------------------------------------------------------
  // Decision terms
  // --------------------------------------------------------------
  wire eligible   = ev_i.valid & ev_i.has_status_field;          // [RULE6]
  wire mandated   = ev_i.valid & ev_i.scalar_approx & ev_i.operand_extreme; // [RULE11]
  wire par_clear  = ev_i.valid & ev_i.parallel_approx & ev_i.operand_extreme; // [RULE12]
  wire imp_fault  = eligible & ev_i.hw_cannot_finish & ~ev_i.first_round_done;
  wire imp_trap   = eligible & ev_i.first_round_done
                    & (ev_i.hw_cannot_finish | ev_i.inexact);    // [RULE8] [RULE10]
  wire fault      = mandated | imp_fault | (ev_i.valid & ev_i.other_fault);
  wire trap       = imp_trap & ~fault;

  // Kind and code selection
  assign kind_o       = fault ? fp_assist_pkg::KIND_FAULT :
                        trap  ? fp_assist_pkg::KIND_TRAP  : fp_assist_pkg::KIND_NONE;
  assign assist_o     = mandated | imp_fault | trap;
  assign clear_pred_o = par_clear & ~fault;
  assign code_o       = {3'h0,
                         trap & ev_i.inexact,                    // [RULE9]
                         trap & ev_i.underflow,
                         trap & ev_i.overflow,
                         trap & ev_i.frac_incremented,
                         assist_o};                              // [RULE7]

endmodule

/* File: dv/fp_assist_monitor.sv */
`timescale 1ns/100ps
module fp_assist_monitor (
  input wire                           SYS_CLK_I,
  input wire                           RESET_I,
  input wire fp_assist_pkg::fp_event_t EVENT_I,
  input wire [63:0]                    RESULT_I,
  input wire                           VECTOR_VALID_O,
  input wire [15:0]                    VECTOR_O,
  input wire [63:0]                    INTERRUPTION_BUNDLE_POINTER_O,
  input wire [1:0]                     SAVED_RESTART_SLOT_INDEX_O,
  input wire [63:0]                    INTERRUPTION_PREVIOUS_ADDRESS_O,
  input wire [1:0]                     EXCEPTION_SLOT_INDEX_O,
  input wire [7:0]                     INTERRUPTION_STATUS_CODE_O,
  input wire                           DEST_WR_O,
  input wire [63:0]                    DEST_DATA_O,
  input wire                           PRED_CLEAR_O
);
  fp_assist_pkg::fp_event_t e;
  assign e = EVENT_I;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // ----------------------------------------------------------------
  // Event classes
  // ----------------------------------------------------------------
  sequence s_mand;
    e.valid && e.scalar_approx && e.operand_extreme;
  endsequence
  sequence s_trap;
    e.valid && e.has_status_field && e.first_round_done && e.hw_cannot_finish
      && !e.scalar_approx && !e.other_fault;
  endsequence
  sequence s_par;
    e.valid && e.parallel_approx && e.operand_extreme && !e.scalar_approx
      && !e.other_fault && !e.has_status_field;
  endsequence
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fault_vector: assert property (s_mand |=> VECTOR_VALID_O && VECTOR_O == 16'h5c00
    && INTERRUPTION_STATUS_CODE_O[0]) else $error("fault vector wrong");
  a_fault_record: assert property (s_mand |=> SAVED_RESTART_SLOT_INDEX_O == $past(e.slot)
    && INTERRUPTION_BUNDLE_POINTER_O == $past(e.bundle_addr)) else $error("fault record");
  a_fault_keep: assert property (s_mand |=> !DEST_WR_O) else $error("fault wrote");
  a_trap_vector: assert property (s_trap |=> VECTOR_VALID_O && VECTOR_O == 16'h5d00)
    else $error("trap vector wrong");
  a_trap_record: assert property (s_trap |=> EXCEPTION_SLOT_INDEX_O == $past(e.slot)
    && INTERRUPTION_PREVIOUS_ADDRESS_O == $past(e.bundle_addr)) else $error("trap record");
  a_trap_code: assert property (s_trap |=> INTERRUPTION_STATUS_CODE_O[4:0] ==
    {$past(e.inexact), $past(e.underflow), $past(e.overflow), $past(e.frac_incremented), 1'b1})
    else $error("trap code wrong");
  a_trap_result: assert property (s_trap |=> DEST_WR_O && DEST_DATA_O == $past(RESULT_I))
    else $error("trap result wrong");
  a_pred_clear: assert property (s_par |=> PRED_CLEAR_O && !VECTOR_VALID_O)
    else $error("predicate not cleared");
  a_no_status: assert property (e.valid && !e.has_status_field && !e.scalar_approx
    && !e.other_fault |=> !VECTOR_VALID_O) else $error("assist without status field");
endmodule

bind fp_assist_unit fp_assist_monitor fp_assist_monitor_i (.SYS_CLK_I, .RESET_I, .EVENT_I,
  .RESULT_I, .VECTOR_VALID_O, .VECTOR_O, .INTERRUPTION_BUNDLE_POINTER_O,
  .SAVED_RESTART_SLOT_INDEX_O, .INTERRUPTION_PREVIOUS_ADDRESS_O, .EXCEPTION_SLOT_INDEX_O,
  .INTERRUPTION_STATUS_CODE_O, .DEST_WR_O, .DEST_DATA_O, .PRED_CLEAR_O);

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
  logic                     clk = 1'b0, rst = 1'b1, ar_wr = 1'b0, vv, dw, pc;
  fp_assist_pkg::fp_event_t ev = '0;
  logic [63:0]              res = '0, flg = '0, wd = '0, st, rd, ibp, ipa, dd;
  logic [6:0]               ad = '0;
  logic [15:0]              vec;
  logic [7:0]               code;
  logic [1:0]               sri, esi;
  logic [156:0]             q[$], obs, exp_e;
  int                       error_cnt = 0, check_count = 0;

  fp_assist_unit fp_assist_unit_i (.SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1),
    .EVENT_I(ev), .RESULT_I(res), .FLAGS_UPDATE_I(flg), .AR_WR_I(ar_wr), .AR_ADDR_I(ad),
    .AR_WDATA_I(wd), .AR_RDATA_O(rd), .VECTOR_VALID_O(vv), .VECTOR_O(vec),
    .INTERRUPTION_BUNDLE_POINTER_O(ibp), .SAVED_RESTART_SLOT_INDEX_O(sri),
    .INTERRUPTION_PREVIOUS_ADDRESS_O(ipa), .EXCEPTION_SLOT_INDEX_O(esi),
    .INTERRUPTION_STATUS_CODE_O(code), .DEST_WR_O(dw), .DEST_DATA_O(dd), .PRED_CLEAR_O(pc));

  // Clock, 5 ns period
  initial forever #2.5 clk = ~clk;

  task automatic chk(string n, logic [156:0] e, logic [156:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Register access, data valid after return
  task automatic ar(logic w, logic [6:0] a, logic [63:0] d);
    @(posedge clk);
    ar_wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    ar_wr <= 1'b0;
  endtask

  // One event of class k, expected outcome queued
  task automatic send(int k);
    fp_assist_pkg::fp_event_t e;
    logic [63:0]              r, f;
    logic [7:0]               c;
    e = '0;
    r = {$urandom, $urandom};
    f = {$urandom, $urandom};
    e.valid = 1'b1;
    e.bundle_addr = {$urandom, $urandom};
    e.slot = 2'($urandom % 3);
    e.has_status_field = k inside {2, 3};
    e.first_round_done = e.has_status_field;
    e.scalar_approx = k == 0;
    e.other_fault = k == 1;
    e.hw_cannot_finish = k inside {2, 5};
    e.parallel_approx = k == 4;
    e.operand_extreme = k inside {0, 4};
    e.inexact = k == 3;
    if (k == 2) {e.inexact, e.underflow, e.overflow, e.frac_incremented} = 4'($urandom);
    c = {3'h0, e.inexact, e.underflow, e.overflow, e.frac_incremented, k != 1};
    @(posedge clk);
    ev <= e;
    res <= r;
    flg <= f;
    if (k > 1) st = st | f;
    q.push_back({k < 4, k < 2 ? 16'h5c00 : k < 4 ? 16'h5d00 : 16'h0, k < 4 ? c : 8'h0,
      k > 1, k == 4, k > 1 ? r : 64'h0, k < 4 ? {e.bundle_addr, e.slot} : 66'h0});
  endtask

  // Pop and compare on each result pulse
  always @(negedge clk) if (vv | dw | pc) begin
    obs = {vv, vv ? vec : 16'h0, vv ? code : 8'h0, dw, pc, dw ? dd : 64'h0,
      !vv ? 66'h0 : vec == 16'h5d00 ? {ipa, esi} : {ibp, sri}};
    if (q.size() == 0) chk("unexpected", 157'h0, obs);
    else begin
      exp_e = q.pop_front();
      chk("vector", exp_e[156:132], obs[156:132]);
      chk("dest", exp_e[131:66], obs[131:66]);
      chk("record", exp_e[65:0], obs[65:0]);
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h93cc));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ar(0, 7'h28, 0);
    @(negedge clk);
    chk("status_reset", 0, rd);
    st = {$urandom, $urandom};
    ar(1, 7'h28, st);
    ar(1, 7'h29, ~st);
    ar(0, 7'h28, 0);
    @(negedge clk);
    chk("status_rw", st, rd);
    $display("test registers done");
    for (int i = 0; i < 300; i++) send($urandom % 6);
    @(posedge clk);
    ev <= '0;
    flg <= '0;
    for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge clk);
    chk("queue_drain", 157'h0, 157'(q.size()));
    $display("test events done");
    ar(0, 7'h28, 0);
    @(negedge clk);
    chk("status_flags", st, rd);
    ar(0, 7'h29, 0);
    @(negedge clk);
    chk("unmapped", 0, rd);
    $display("test flags done");
    close_out();
  end
endmodule
